// *** reset_strap_test_point_port_tb.sv ***
// Self-checking bench for the reset strap test point port.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errCount++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module reset_strap_test_point_port_tb;
	import rstp_pkg::*;
	// Reset starts high so that its first fall reaches the design.
	logic sysClk = 0, rstN = 1, fwSelValid = 0, c60 = 0, c30 = 0;
	logic c7 = 0, cv = 0;
	logic [2:0] fwSel = 0, pullMask = 0, activeSel;
	logic [7:0] tpIn, tpPulldownEn;
	logic [4:0] strapOptions;
	logic strapDone;
	rstp_pin_s tpPin;
	rstp_clksrc_s clkSrc;
	int errCount = 0, checks = 0, cycles = 0;
	rstp_port u_rstp_port (.sys_clk(sysClk), .rst_n(rstN), .tpIn(tpIn),
		.tpPin(tpPin), .tpPulldownEn(tpPulldownEn),
		.clkSrc(clkSrc), .fwSelValid(fwSelValid),
		.fwSel(fwSel), .strapDone(strapDone), .activeSel(activeSel),
		.strapOptions(strapOptions));
	rstp_board u_rstp_board (.tpPin(tpPin), .tpPulldownEn(tpPulldownEn),
		.pullMask(pullMask), .tpIn(tpIn));
	assign clkSrc = '{clk60: c60, clk30: c30, clk7p5: c7, clkVar: cv};
	initial forever #5 sysClk = ~sysClk;
	initial forever #8.33 c60 = ~c60;
	initial forever #16.67 c30 = ~c30;
	initial forever #66.67 c7 = ~c7;
	initial forever #23.33 cv = ~cv;
	always @(posedge sysClk) begin
		cycles++;
		if (cycles == 3000) begin
			errCount++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Straps are fitted, reset is held four cycles, then released.
	task automatic strap_reset(input logic [2:0] mask);
		@(posedge sysClk) begin pullMask <= mask; rstN <= 1'b0; end
		repeat (3) @(posedge sysClk);
		#1 `CHK(tpPin.drive, 8'h00)
		@(posedge sysClk) rstN <= 1'b1;
		@(posedge sysClk) #1;
		`CHK(strapDone, 1'b1)
		`CHK(activeSel, mask)
		`CHK(tpPulldownEn, 8'hFF)
		`CHK(strapOptions, 5'h00)
	endtask
	task automatic fw_write(input logic [2:0] sel);
		@(posedge sysClk) begin fwSelValid <= 1'b1; fwSel <= sel; end
		@(posedge sysClk) fwSelValid <= 1'b0;
		#1 `CHK(activeSel, sel)
	endtask
	task automatic test_quiet();
		strap_reset(3'h0);
		`CHK(tpPin.drive, 8'h00)
		`CHK(tpPin.level, 8'h00)
		// Pins stay released here, so a new strap reaches the synchroniser.
		@(posedge sysClk) pullMask <= 3'h2;
		repeat (4) @(posedge sysClk);
		#1 `CHK(activeSel, 3'h0)
		`CHK(tpPin.drive, 8'h00)
		$display("test quiet done");
	endtask
	task automatic test_clock_debug();
		strap_reset(3'h2);
		`CHK(tpPin.drive, 8'hFF)
		`CHK(tpPin.level[6:3], 4'hD)
		repeat (6) begin
			@(posedge sysClk) pullMask <= 3'h5;
			#1 `CHK(tpPin.level[0], c60)
			`CHK(tpPin.level[1], c30)
			`CHK(tpPin.level[7], c7)
			`CHK(tpPin.level[2], cv)
		end
		`CHK(activeSel, 3'h2)
		$display("test clock debug done");
	endtask
	task automatic test_other_codes();
		for (int k = 1; k < 8; k++) begin
			if (k != 2) begin
				strap_reset(k[2:0]);
				`CHK(tpPin.drive, 8'h00)
			end
		end
		$display("test other codes done");
	endtask
	task automatic test_firmware();
		strap_reset(3'h0);
		fw_write(3'h2);
		`CHK(tpPin.drive, 8'hFF)
		fw_write(3'h6);
		`CHK(tpPin.drive, 8'h00)
		$display("test firmware done");
	endtask
	initial begin
		test_quiet();
		test_clock_debug();
		test_other_codes();
		test_firmware();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// *** rstp_board.sv ***
// Board model: strap resistors and the device's weak pulldowns.
`timescale 1ns/10ps
`default_nettype none
module rstp_board (
	// Device side.
	input  wire rstp_pkg::rstp_pin_s tpPin,
	input  wire logic [7:0]          tpPulldownEn,
	// Strap fitting and resolved pin levels.
	input  wire logic [2:0]          pullMask,
	output logic [7:0]               tpIn
);
	import rstp_pkg::*;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (tpPin.drive[i]) begin
				tpIn[i] = tpPin.level[i];
			end else if (i < 3 && pullMask[i]) begin
				tpIn[i] = 1'b1;
			end else begin
				tpIn[i] = !tpPulldownEn[i];
			end
		end
	end
endmodule
`default_nettype wire

// *** rstp_pkg.sv ***
// Shared constants and types for the reset strap test point port.
`default_nettype none
package rstp_pkg;
	localparam int unsigned TP_WIDTH = 8;
	localparam int unsigned SEL_WIDTH = 3;
	// Strap value after reset, selection codes and selection after reset.
	localparam logic [7:0] STRAP_RESET = 8'h00;
	localparam logic [2:0] SEL_QUIET = 3'h0;
	localparam logic [2:0] SEL_CLKDBG = 3'h2;
	localparam logic [2:0] SEL_RESET = 3'h0;
	// Pin positions of the clock debug pattern.
	localparam int unsigned TP_CLK60 = 0;
	localparam int unsigned TP_CLK30 = 1;
	localparam int unsigned TP_CLKVAR = 2;
	localparam int unsigned TP_CLK7P5 = 7;
	// Static levels driven in clock debug, one bit per test point.
	localparam logic [7:0] CLKDBG_LEVELS = 8'h68;
	localparam logic [7:0] CLKDBG_STATIC_MASK = 8'h78;
	localparam logic [7:0] DRIVE_NONE = 8'h00;
	localparam logic [7:0] DRIVE_ALL = 8'hFF;
	localparam logic [7:0] PULLDOWN_ALL = 8'hFF;
	// Nominal rates of the forwarded debug clocks, in kHz.
	localparam int unsigned CLK60_FREQ_KHZ = 60000;
	localparam int unsigned CLK30_FREQ_KHZ = 30000;
	localparam int unsigned CLK7P5_FREQ_KHZ = 7500;
	localparam int unsigned CLKVAR_MIN_KHZ = 700;
	localparam int unsigned CLKVAR_MAX_KHZ = 22500;
	// Upper strap bits start at this position.
	localparam int unsigned OPT_LSB = 3;

	typedef enum logic {
		MODE_QUIET,
		MODE_CLKDBG
	} rstp_mode_e;

	// Test point pin group: output level and output enable per pin.
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] drive;
	} rstp_pin_s;

	// Debug clock sources forwarded to the pins.
	typedef struct packed {
		logic clk60;
		logic clk30;
		logic clk7p5;
		logic clkVar;
	} rstp_clksrc_s;
endpackage
`default_nettype wire

// *** rstp_port.sv ***
// Reset strap capture and test point output selection.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// (RL1) Pins are inputs in reset, outputs afterwards only in clock debug.
// (RL2) Straps sampled only at reset release.
// (RL3) Captured value holds until next reset.
// (RL4) Weak pulldowns make unstrapped pins read zero.
// (RL5) Selection x000 keeps all pins high impedance.
// (RL6) Clock debug drives 60, 30, 7.5 MHz.
// (RL7) Clock debug: variable clock, fixed levels.
// (RL8) Board straps only the low three pins.
// (RL9) Firmware may overwrite the selection later.
// (RL10) Other selections keep pins high impedance.
module rstp_port (
	// Clock and reset.
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	// Test point pins.
	input  wire logic [7:0]            tpIn,
	output var rstp_pkg::rstp_pin_s    tpPin,
	output logic [7:0]                 tpPulldownEn,
	// Debug clock sources.
	input  wire rstp_pkg::rstp_clksrc_s clkSrc,
	// Firmware selection.
	input  wire logic                  fwSelValid,
	input  wire logic [2:0]            fwSel,
	// Captured state.
	output logic                       strapDone,
	output logic [2:0]                 activeSel,
	output logic [4:0]                 strapOptions
);
	import rstp_pkg::*;

	logic [7:0] pinMeta;
	logic [7:0] pinSync;
	logic [7:0] strapVal;
	logic       captured;
	logic [2:0] modeSel;
	rstp_mode_e mode;
	rstp_pin_s  next_pin;

	// Pin synchroniser; it carries no reset so it holds the strap
	// levels seen while reset is low.
	always_ff @(posedge sys_clk) begin
		pinMeta <= tpIn;
		pinSync <= pinMeta;
	end

	// Straps are taken once, at the first edge after reset release.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			captured <= 1'b0;
			strapVal <= STRAP_RESET;
		end else if (!captured) begin
			captured <= 1'b1; // see (RL2)
			strapVal <= pinSync; // see (RL2)
		end
	end

	// Selection: strap default, later overwritten by firmware.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			modeSel <= SEL_RESET;
		end else if (!captured) begin
			modeSel <= pinSync[2:0]; // see (RL3)
		end else if (fwSelValid) begin
			modeSel <= fwSel; // see (RL9)
		end
	end

	// Only the documented clock debug code enables drivers.
	always_comb begin
		unique case (modeSel)
			SEL_CLKDBG: mode = MODE_CLKDBG;
			default:    mode = MODE_QUIET; // see (RL5) see (RL10)
		endcase
	end

	// Pin drive follows the selection once straps are captured.
	always_comb begin
		next_pin.level = CLKDBG_LEVELS & CLKDBG_STATIC_MASK; // see (RL7)
		next_pin.level[TP_CLK60] = clkSrc.clk60; // see (RL6)
		next_pin.level[TP_CLK30] = clkSrc.clk30; // see (RL6)
		next_pin.level[TP_CLK7P5] = clkSrc.clk7p5; // see (RL6)
		next_pin.level[TP_CLKVAR] = clkSrc.clkVar; // see (RL7)
		next_pin.drive = DRIVE_NONE; // see (RL1)
		if (captured && mode == MODE_CLKDBG) begin
			next_pin.drive = DRIVE_ALL;
		end
		if (!captured || mode == MODE_QUIET) begin
			next_pin.level = DRIVE_NONE;
		end
	end

	assign tpPin = next_pin;
	assign tpPulldownEn = PULLDOWN_ALL; // see (RL4)
	assign strapDone = captured;
	assign activeSel = modeSel;
	assign strapOptions = strapVal[7:OPT_LSB]; // see (RL8)

	// Checks on the strap capture and pin drive.
	a_inputs_before_capture: assert property ( // see (RL1)
		@(posedge sys_clk) disable iff (!rst_n)
		!captured |-> tpPin.drive == DRIVE_NONE)
		else $error("Test points driven before strap capture.");

	a_capture_at_release: assert property ( // see (RL2)
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(captured) |-> strapVal == $past(pinSync))
		else $error("Strap value differs from pins at release.");

	a_strap_ignored_later: assert property ( // see (RL2)
		@(posedge sys_clk) disable iff (!rst_n)
		captured ##1 captured |-> $stable(strapVal))
		else $error("Strap value changed after capture.");

	a_mode_holds: assert property ( // see (RL3)
		@(posedge sys_clk) disable iff (!rst_n)
		captured && !fwSelValid |=> $stable(modeSel))
		else $error("Selection changed without firmware write.");

	a_pulldown_on: assert property ( // see (RL4)
		@(posedge sys_clk) disable iff (!rst_n)
		tpPulldownEn == PULLDOWN_ALL)
		else $error("Test point pulldown released.");

	a_quiet_hiz: assert property ( // see (RL5)
		@(posedge sys_clk) disable iff (!rst_n)
		modeSel == SEL_QUIET |-> tpPin.drive == DRIVE_NONE)
		else $error("Pins driven in quiet selection.");

	a_clkdbg_clocks: assert property ( // see (RL6)
		@(posedge sys_clk) disable iff (!rst_n)
		captured && modeSel == SEL_CLKDBG |->
			tpPin.drive == DRIVE_ALL &&
			tpPin.level[TP_CLK60] == clkSrc.clk60 &&
			tpPin.level[TP_CLK30] == clkSrc.clk30 &&
			tpPin.level[TP_CLK7P5] == clkSrc.clk7p5)
		else $error("Debug clocks not on their test points.");

	a_clkdbg_levels: assert property ( // see (RL7)
		@(posedge sys_clk) disable iff (!rst_n)
		captured && modeSel == SEL_CLKDBG |->
			tpPin.level[6:3] == 4'hD &&
			tpPin.level[TP_CLKVAR] == clkSrc.clkVar)
		else $error("Debug static levels or variable clock wrong.");

	a_fw_override: assert property ( // see (RL9)
		@(posedge sys_clk) disable iff (!rst_n)
		captured && fwSelValid |=> modeSel == $past(fwSel))
		else $error("Firmware selection not applied.");

	a_other_hiz: assert property ( // see (RL10)
		@(posedge sys_clk) disable iff (!rst_n)
		modeSel != SEL_CLKDBG |-> tpPin.drive == DRIVE_NONE)
		else $error("Pins driven for undocumented selection.");

	// Reset, hold and firmware checks.
	a_reset_hiz: assert property ( // see (RL1)
		@(posedge sys_clk)
		!rst_n |-> tpPin.drive == DRIVE_NONE && !strapDone)
		else $error("Test points driven or capture flagged in reset.");

	a_sel_from_strap: assert property ( // see (RL3)
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(captured) |-> modeSel == strapVal[2:0])
		else $error("Selection differs from captured straps.");

	a_capture_holds: assert property ( // see (RL3)
		@(posedge sys_clk) disable iff (!rst_n)
		captured |=> captured)
		else $error("Capture flag dropped without reset.");

	a_options_stable: assert property ( // see (RL2)
		@(posedge sys_clk) disable iff (!rst_n)
		captured |=> $stable(strapOptions))
		else $error("Upper strap bits changed after capture.");

	a_quiet_level: assert property ( // see (RL5)
		@(posedge sys_clk) disable iff (!rst_n)
		modeSel == SEL_QUIET |-> tpPin.level == DRIVE_NONE)
		else $error("Pin levels switch in quiet selection.");

	a_other_level: assert property ( // see (RL10)
		@(posedge sys_clk) disable iff (!rst_n)
		modeSel != SEL_CLKDBG |-> tpPin.level == DRIVE_NONE)
		else $error("Pin levels switch for undocumented selection.");

	a_drive_whole_port: assert property ( // see (RL6)
		@(posedge sys_clk) disable iff (!rst_n)
		tpPin.drive == DRIVE_NONE || tpPin.drive == DRIVE_ALL)
		else $error("Test point drivers only partly enabled.");

	a_capture_wins: assert property ( // see (RL9)
		@(posedge sys_clk) disable iff (!rst_n)
		!captured |=> modeSel == strapVal[2:0])
		else $error("Firmware write taken before strap capture.");

	a_fw_enables_drive: assert property ( // see (RL9)
		@(posedge sys_clk) disable iff (!rst_n)
		captured && fwSelValid && fwSel == SEL_CLKDBG |=>
			tpPin.drive == DRIVE_ALL)
		else $error("Firmware clock debug selection not driven.");

	c_capture_quiet: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(captured) && strapVal[2:0] == SEL_QUIET);

	c_capture_clkdbg: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(captured) && strapVal[2:0] == SEL_CLKDBG);

	c_fw_to_clkdbg: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		captured && fwSelValid && fwSel == SEL_CLKDBG ##1
			tpPin.drive == DRIVE_ALL);

	c_capture_other: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(captured) && strapVal[2:0] == 3'h5);

	c_fw_to_quiet: cover property (
		@(posedge sys_clk) disable iff (!rst_n)
		captured && fwSelValid && fwSel != SEL_CLKDBG ##1
			tpPin.drive == DRIVE_NONE);
endmodule
`default_nettype wire
